// ==== rtl/pdmmic_consts.svh ====
// constants of the pdm microphone interface
`ifndef PDMMIC_CONSTS_SVH
`define PDMMIC_CONSTS_SVH

// ============================================================
// widths
`define PDMMIC_LEVEL_W 8
`define PDMMIC_PER_CNT_W 8

// ============================================================
// timing
`define PDMMIC_CORE_PERIOD_NS 10
`define PDMMIC_MIC_MIN_KHZ 1000
`define PDMMIC_MIC_MAX_KHZ 3300
// shortest legal mic period, rounded up to core cycles
`define PDMMIC_PER_MIN_CYC ((1000000 + `PDMMIC_MIC_MAX_KHZ * \
  `PDMMIC_CORE_PERIOD_NS - 1) / (`PDMMIC_MIC_MAX_KHZ * `PDMMIC_CORE_PERIOD_NS))
// longest legal mic period, rounded down to core cycles
`define PDMMIC_PER_MAX_CYC (1000000 / (`PDMMIC_MIC_MIN_KHZ * \
  `PDMMIC_CORE_PERIOD_NS))

`endif

// ==== rtl/pdmmic_pkg.sv ====
// types of the pdm microphone interface
package pdmmic_pkg;

  // ============================================================
  // level hand-over from core to link domain
  typedef enum logic [0:0] {
    PDMMIC_HS_IDLE,
    PDMMIC_HS_WAIT
  } pdmmic_hs_e;

endpackage

// ==== rtl/pdmmic_top.sv ====
// microphone side of a pdm link: modulator, edge select, data drive
`include "pdmmic_consts.svh"

module pdmmic_top #(
  parameter int LEVEL_W = `PDMMIC_LEVEL_W,
  parameter int PER_CNT_W = `PDMMIC_PER_CNT_W
) (
  // core clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // input level, unsigned fraction of full scale
  input wire logic [LEVEL_W-1:0] level_i,
  input wire logic level_valid_i,
  output logic level_ready_o,
  // core-side status
  output logic clk_ok_o,
  output logic chan_sel_o,
  // link pins
  input wire logic mic_clk_i,
  input wire logic chan_sel_i,
  output logic data_o,
  output logic data_oe_o
);

  localparam int ACC_W = LEVEL_W + 3;
  localparam logic [PER_CNT_W-1:0] PER_MIN = PER_CNT_W'(`PDMMIC_PER_MIN_CYC);
  localparam logic [PER_CNT_W-1:0] PER_MAX = PER_CNT_W'(`PDMMIC_PER_MAX_CYC);
  localparam logic [PER_CNT_W-1:0] PER_SAT = {PER_CNT_W{1'b1}};
  localparam logic signed [ACC_W-1:0] FULL = ACC_W'(1) <<< LEVEL_W;
  localparam logic signed [ACC_W-1:0] HALF = ACC_W'(1) <<< (LEVEL_W - 1);
  localparam logic [LEVEL_W-1:0] LEVEL_RST = LEVEL_W'(1) << (LEVEL_W - 1);

  // ============================================================
  // core domain: level hand-over, toggle handshake
  pdmmic_pkg::pdmmic_hs_e hs_r, hs_nxt;
  logic [LEVEL_W-1:0] core_level_r, core_level_nxt;
  logic req_r, req_nxt;
  logic ack_meta_r, ack_sync_r;
  // link-side acknowledge toggle, read here only through two flops
  logic ack_r, ack_nxt;

  always_comb begin
    hs_nxt = hs_r;
    core_level_nxt = core_level_r;
    req_nxt = req_r;
    case (hs_r)
      pdmmic_pkg::PDMMIC_HS_IDLE: begin
        if (level_valid_i) begin
          core_level_nxt = level_i;
          req_nxt = ~req_r;
          hs_nxt = pdmmic_pkg::PDMMIC_HS_WAIT;
        end
      end
      pdmmic_pkg::PDMMIC_HS_WAIT: begin
        // word must stay still until the link side has taken it
        if (ack_sync_r == req_r) begin
          hs_nxt = pdmmic_pkg::PDMMIC_HS_IDLE;
        end
      end
      default: begin
        hs_nxt = pdmmic_pkg::PDMMIC_HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hs_r <= pdmmic_pkg::PDMMIC_HS_IDLE;
      core_level_r <= LEVEL_RST;
      req_r <= 1'b0;
      ack_meta_r <= 1'b0;
      ack_sync_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      core_level_r <= core_level_nxt;
      req_r <= req_nxt;
      ack_meta_r <= ack_r;
      ack_sync_r <= ack_meta_r;
    end
  end

  assign level_ready_o = (hs_r == pdmmic_pkg::PDMMIC_HS_IDLE);

  // ============================================================
  // core domain: mic clock period monitor and select readback
  logic mclk_meta_r, mclk_sync_r, mclk_prev_r;
  logic csel_meta_r, csel_sync_r;
  logic [PER_CNT_W-1:0] per_cnt_r, per_cnt_nxt;
  logic clk_ok_r, clk_ok_nxt;

  always_comb begin
    per_cnt_nxt = per_cnt_r;
    clk_ok_nxt = clk_ok_r;
    if (mclk_sync_r && !mclk_prev_r) begin
      // judge each full period; counter includes the edge cycle
      clk_ok_nxt = (per_cnt_r >= PER_MIN) && (per_cnt_r <= PER_MAX);
      per_cnt_nxt = PER_CNT_W'(1);
    end else if (per_cnt_r != PER_SAT) begin
      per_cnt_nxt = per_cnt_r + PER_CNT_W'(1);
    end
    // a stopped clock is reported as soon as it overstays
    if (per_cnt_r > PER_MAX) begin
      clk_ok_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mclk_meta_r <= 1'b0;
      mclk_sync_r <= 1'b0;
      mclk_prev_r <= 1'b0;
      csel_meta_r <= 1'b0;
      csel_sync_r <= 1'b0;
      per_cnt_r <= PER_SAT;
      clk_ok_r <= 1'b0;
    end else begin
      mclk_meta_r <= mic_clk_i;
      mclk_sync_r <= mclk_meta_r;
      mclk_prev_r <= mclk_sync_r;
      csel_meta_r <= chan_sel_i;
      csel_sync_r <= csel_meta_r;
      per_cnt_r <= per_cnt_nxt;
      clk_ok_r <= clk_ok_nxt;
    end
  end

  assign clk_ok_o = clk_ok_r;
  assign chan_sel_o = csel_sync_r;

  // ============================================================
  // link domain: reset release synchronised to the mic clock
  logic lrst_meta_r, lrst_n_r;

  always_ff @(posedge mic_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lrst_meta_r <= 1'b0;
      lrst_n_r <= 1'b0;
    end else begin
      lrst_meta_r <= 1'b1;
      lrst_n_r <= lrst_meta_r;
    end
  end

  // ============================================================
  // link domain: level capture and delta-sigma loop
  logic req_meta_r, req_sync_r;
  logic [LEVEL_W-1:0] link_level_r, link_level_nxt;
  logic sel_meta_r, sel_r;
  logic signed [ACC_W-1:0] integ_r, integ_nxt;
  logic bit_r, bit_nxt;

  always_comb begin
    ack_nxt = ack_r;
    link_level_nxt = link_level_r;
    if (req_sync_r != ack_r) begin
      link_level_nxt = core_level_r;
      ack_nxt = req_sync_r;
    end
    // integrate input minus the previous bit, slice at half scale
    integ_nxt = integ_r + $signed({3'b000, link_level_r})
              - (bit_r ? FULL : '0);
    // high density of ones stands for positive amplitude
    bit_nxt = (integ_nxt >= HALF);
  end

  always_ff @(posedge mic_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      req_meta_r <= 1'b0;
      req_sync_r <= 1'b0;
      ack_r <= 1'b0;
      link_level_r <= LEVEL_RST;
      sel_meta_r <= 1'b0;
      sel_r <= 1'b0;
      integ_r <= '0;
      bit_r <= 1'b0;
    end else begin
      req_meta_r <= req_r;
      req_sync_r <= req_meta_r;
      ack_r <= ack_nxt;
      link_level_r <= link_level_nxt;
      sel_meta_r <= chan_sel_i;
      sel_r <= sel_meta_r;
      integ_r <= integ_nxt;
      bit_r <= bit_nxt;
    end
  end

  // ============================================================
  // link domain: edge-selected launch and half-cycle drive
  // toggle pairs open the window on the launch edge and close it on
  // the capture edge, both through flops, so the host sees data held
  // across its capture edge without a zero-delay race
  logic fall_data_r, fall_data_nxt;
  logic neg_tog_r, neg_tog_nxt;
  logic pos_cpy_r, pos_cpy_nxt;
  logic pos_tog_r, pos_tog_nxt;
  logic neg_cpy_r, neg_cpy_nxt;

  always_comb begin
    // select low: launch on falling edge for rising capture
    fall_data_nxt = bit_r;
    neg_tog_nxt = ~neg_tog_r;
    neg_cpy_nxt = pos_tog_r;
    pos_tog_nxt = ~pos_tog_r;
    pos_cpy_nxt = neg_tog_r;
  end

  always_ff @(negedge mic_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      fall_data_r <= 1'b0;
      neg_tog_r <= 1'b0;
      neg_cpy_r <= 1'b0;
    end else begin
      fall_data_r <= fall_data_nxt;
      neg_tog_r <= neg_tog_nxt;
      neg_cpy_r <= neg_cpy_nxt;
    end
  end

  always_ff @(posedge mic_clk_i or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      pos_tog_r <= 1'b0;
      pos_cpy_r <= 1'b0;
    end else begin
      pos_tog_r <= pos_tog_nxt;
      pos_cpy_r <= pos_cpy_nxt;
    end
  end

  logic low_win, high_win;

  assign low_win = (neg_tog_r != pos_cpy_r);
  assign high_win = (pos_tog_r != neg_cpy_r);
  // select high: bit launched on rising edge for falling capture
  assign data_o = sel_r ? bit_r : fall_data_r;
  // release the line in the other half so a second mic can use it
  assign data_oe_o = lrst_n_r && (sel_r ? high_win : low_win);

endmodule

// ==== verif/pdmmic_top_asserts.sv ====
// concurrent checks on the pdm microphone block ports
module pdmmic_top_asserts #(
  parameter int LEVEL_W = 8,
  parameter int PER_CNT_W = 8
) (
  // core side
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [LEVEL_W-1:0] level_i,
  input wire logic level_valid_i,
  input wire logic level_ready_o,
  input wire logic clk_ok_o,
  input wire logic chan_sel_o,
  // link pins
  input wire logic mic_clk_i,
  input wire logic chan_sel_i,
  input wire logic data_o,
  input wire logic data_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // link drive window, judged only once select has settled
  a_rise_drive: assert property (
    @(posedge mic_clk_i) disable iff (!reset_n_i)
    !chan_sel_i && !$past(chan_sel_i, 4) && $past(reset_n_i, 6)
    |-> data_oe_o)
    else $error("data not driven up to rising capture edge");
  a_fall_drive: assert property (
    @(negedge mic_clk_i) disable iff (!reset_n_i)
    chan_sel_i && $past(chan_sel_i, 4) && $past(reset_n_i, 6)
    |-> data_oe_o)
    else $error("data not driven up to falling capture edge");
  a_rise_idle: assert property (
    @(posedge mic_clk_i) disable iff (!reset_n_i)
    chan_sel_i && $past(chan_sel_i, 4) && $past(reset_n_i, 6)
    |-> !data_oe_o)
    else $error("data driven in the other channel's half");
  a_fall_idle: assert property (
    @(negedge mic_clk_i) disable iff (!reset_n_i)
    !chan_sel_i && !$past(chan_sel_i, 4) && $past(reset_n_i, 6)
    |-> !data_oe_o)
    else $error("data driven in the other channel's half");
  // ==========
  // core side
  a_level_take: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    level_valid_i && level_ready_o |=> !level_ready_o [*2])
    else $error("level taken but ready stayed high");
  a_sel_follow: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    $past(reset_n_i, 2) |-> chan_sel_o == $past(chan_sel_i, 2))
    else $error("select status does not follow the pin");
endmodule

// ==== verif/pdmmic_host_model.sv ====
// host-side model: mic clock, edge select, windowed ones counter
module pdmmic_host_model (
  // control from bench
  input wire logic reset_n_i,
  input wire logic run_i,
  input var real half_ns_i,
  input wire logic sel_i,
  // link pins
  output logic mic_clk_o,
  output logic chan_sel_o,
  input wire logic pdm_i,
  // window result
  output logic [7:0] ones_o,
  output logic [7:0] ones_b_o,
  output logic win_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_r;
  logic [7:0] cnt_b_r;
  logic [6:0] pos_r;
  logic cap;
  initial mic_clk_o = 1'b0;
  // clock halts when stopped, never runs free
  always begin
    if (!run_i) wait (run_i);
    #(half_ns_i) mic_clk_o = ~mic_clk_o;
  end
  assign chan_sel_o = sel_i;
  assign cap = chan_sel_o ? ~mic_clk_o : mic_clk_o;
  always @(posedge cap or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 8'h00;
      cnt_b_r <= 8'h00;
      pos_r <= 7'h00;
      ones_o <= 8'h00;
      ones_b_o <= 8'h00;
      win_o <= 1'b0;
    end else begin
      pos_r <= pos_r + 7'd1;
      // second counter closes its window half a window later
      if (pos_r == 7'd63) begin
        ones_b_o <= cnt_b_r + 8'(pdm_i);
        cnt_b_r <= 8'h00;
      end else begin
        cnt_b_r <= cnt_b_r + 8'(pdm_i);
      end
      if (pos_r == 7'd127) begin
        ones_o <= cnt_r + 8'(pdm_i);
        cnt_r <= 8'h00;
        win_o <= ~win_o;
      end else begin
        cnt_r <= cnt_r + 8'(pdm_i);
      end
    end
  end
endmodule

// ==== verif/tb_pdm_microphone_interface.sv ====
// self-checking bench for the pdm microphone block
module tb_pdm_microphone_interface;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] level_i = 8'h00;
  logic level_valid_i = 1'b0;
  logic level_ready_o, clk_ok_o, chan_sel_o, data_o, data_oe_o;
  logic mic_clk_i, chan_sel_i, win;
  logic sel = 1'b0;
  logic run = 1'b1;
  real half_ns = 7.5;
  logic [7:0] ones, ones_b;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  always #5 core_clk_i = ~core_clk_i;
  pdmmic_top dut_u (.core_clk_i, .reset_n_i, .level_i, .level_valid_i,
    .level_ready_o, .clk_ok_o, .chan_sel_o, .mic_clk_i, .chan_sel_i,
    .data_o, .data_oe_o);
  // a released line shows the inverse, not a held value
  pdmmic_host_model host_u (.reset_n_i, .run_i(run), .half_ns_i(half_ns),
    .sel_i(sel), .mic_clk_o(mic_clk_i), .chan_sel_o(chan_sel_i),
    .pdm_i(data_oe_o ? data_o : ~data_o), .ones_o(ones),
    .ones_b_o(ones_b), .win_o(win));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic send_level(input logic [7:0] lvl);
    @(posedge core_clk_i);
    #1 level_i = lvl;
    level_valid_i = 1'b1;
    // ready is judged settled, between edges, then held to the taking edge
    while (level_ready_o !== 1'b1) begin
      @(posedge core_clk_i);
      #1;
    end
    @(posedge core_clk_i);
    #1 level_valid_i = 1'b0;
  endtask
  // ==========
  // ones density per window, both capture edges
  task automatic t_levels;
    logic [7:0] lv [4] = '{8'h00, 8'h66, 8'h80, 8'hff};
    logic [8:0] d;
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk_i);
      #1 sel = s[0];
      foreach (lv[i]) begin
        send_level(lv[i]);
        repeat (3) @(win);
        d = {1'b0, ones} + 9'd1 - {2'b00, lv[i][7:1]};
        check(8'(d <= 9'd2), 8'h01);
        d = {1'b0, ones_b} + 9'd1 - {2'b00, lv[i][7:1]};
        check(8'(d <= 9'd2), 8'h01);
      end
    end
    $display("levels test done");
  endtask
  // ==========
  // clock range monitor
  task automatic t_clock;
    check(8'(clk_ok_o), 8'h00);
    #1 half_ns = 208.0;
    repeat (6) @(posedge mic_clk_i);
    @(posedge core_clk_i);
    #1 check(8'(clk_ok_o), 8'h01);
    run = 1'b0;
    repeat (120) @(posedge core_clk_i);
    #1 check(8'(clk_ok_o), 8'h00);
    $display("clock test done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk_i);
    #1 check(8'(data_oe_o), 8'h00);
    reset_n_i = 1'b1;
    t_levels();
    t_clock();
    complete_run();
  end
endmodule

bind pdmmic_top pdmmic_top_asserts #(.LEVEL_W(LEVEL_W),
  .PER_CNT_W(PER_CNT_W)) chk_u (.core_clk_i, .reset_n_i, .level_i,
  .level_valid_i, .level_ready_o, .clk_ok_o, .chan_sel_o, .mic_clk_i,
  .chan_sel_i, .data_o, .data_oe_o);
